/* eis_defines.svh */
// Register offsets, field positions and reset values of the snapshot bank
`ifndef EIS_DEFINES_SVH
`define EIS_DEFINES_SVH
`define EIS_OFS_EN_UPPER   8'h26
`define EIS_OFS_INPUT_LEVEL_CAPTURE_CMD   8'h27
`define EIS_OFS_LVL_LOWER  8'h28
`define EIS_OFS_LVL_UPPER  8'h29
`define EIS_OFS_CNT_LSB    8'h2A
`define EIS_OFS_CNT_MSB    8'h2B
`define EIS_BIT_LVL_CAP    0
`define EIS_BIT_CNT_CAP    1
`define EIS_RST_EN_UPPER   8'h00
`define EIS_RST_LVL        12'h000
`define EIS_RST_CNT        16'h0000
`define EIS_DEV_ADDR       7'h5A
`define EIS_READ_NONE      8'h00
`endif

/* eis_host_model.sv */
// Two-wire bus host model that drives the snapshot bank
`timescale 1ns/1ps
`default_nettype none
module eis_host_model (
  input  wire logic clock_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_oe_out
);
  // Quarter bit of 125 clocks keeps the bus at 100 kbit/s
  localparam int QTR = 125;

  // Bus idle: clock stands high, data released to the pull-up
  initial
  begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  // All pin changes land on the falling clock edge
  task automatic quarter;
    repeat (QTR) @(negedge clock_in);
  endtask : quarter

  // Start or repeated start, entered with the clock low or idle
  task automatic start;
    sda_oe_out = 1'b0;
    quarter();
    scl_out = 1'b1;
    quarter();
    sda_oe_out = 1'b1;
    quarter();
    scl_out = 1'b0;
    quarter();
  endtask : start

  // Stop condition, data rises while the clock is high
  task automatic stop;
    sda_oe_out = 1'b1;
    quarter();
    scl_out = 1'b1;
    quarter();
    sda_oe_out = 1'b0;
    quarter();
  endtask : stop

  // Nine bits out, nine sampled mid high phase; a one releases the line
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_oe_out = ~tx[i];
      quarter();
      scl_out = 1'b1;
      quarter();
      rx[i] = sda_in;
      quarter();
      scl_out = 1'b0;
      quarter();
    end
  endtask : xfer
endmodule : eis_host_model
`default_nettype wire

/* eis_i2c_slave.sv */
// Serial two-wire slave giving byte access to the register bank
`timescale 1ns/1ps
`default_nettype none
`include "eis_defines.svh"
module eis_i2c_slave (
  input  wire logic   clock_in,
  input  wire logic   rst_in,
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_oe_out,
  eis_reg_if.slave    bus
);
  logic [2:0]          scl_q, scl_d, sda_q, sda_d;
  eis_pkg::eis_state_t st_q, st_d, ret_q, ret_d;
  logic [3:0]          cnt_q, cnt_d;
  logic [7:0]          sh_q, sh_d, ptr_q, ptr_d;
  logic                oe_q, oe_d, wr_d;
  logic                rise, fall, start, stop;

  // Pin samples: stage 0 and 1 synchronise, stage 2 only for edges
  assign scl_d = {scl_q[1:0], scl_in};
  assign sda_d = {sda_q[1:0], sda_in};
  assign rise  = scl_q[1] & ~scl_q[2];
  assign fall  = ~scl_q[1] & scl_q[2];
  assign start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  // Byte framing, acknowledge and pointer auto-increment
  always_comb
  begin
    st_d  = st_q;
    ret_d = ret_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    ptr_d = ptr_q;
    oe_d  = oe_q;
    wr_d  = 1'b0;
    if (start)
    begin
      st_d  = eis_pkg::EIS_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end
    else if (stop)
    begin
      st_d = eis_pkg::EIS_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        eis_pkg::EIS_ADDR, eis_pkg::EIS_PTR, eis_pkg::EIS_WR:
        begin
          if (rise && cnt_q != 4'h8)
          begin
            sh_d  = {sh_q[6:0], sda_q[1]};
            cnt_d = cnt_q + 4'h1;
          end
          else if (fall && cnt_q == 4'h8)
          begin
            cnt_d = 4'h0;
            oe_d  = 1'b1;
            st_d  = eis_pkg::EIS_ACK;
            ret_d = eis_pkg::EIS_WR;
            if (st_q == eis_pkg::EIS_ADDR)
            begin
              ret_d = sh_q[0] ? eis_pkg::EIS_RD : eis_pkg::EIS_PTR;
              if (sh_q[7:1] != `EIS_DEV_ADDR)
              begin
                oe_d = 1'b0; // Not ours: stay off the line
                st_d = eis_pkg::EIS_IDLE;
              end
            end
            else if (st_q == eis_pkg::EIS_PTR)
              ptr_d = sh_q;
            else
            begin
              wr_d  = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        eis_pkg::EIS_ACK:
          if (fall)
          begin
            st_d = ret_q;
            oe_d = 1'b0;
            if (ret_q == eis_pkg::EIS_RD)
            begin
              sh_d  = {bus.rdata[6:0], 1'b0};
              oe_d  = ~bus.rdata[7];
              cnt_d = 4'h1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        eis_pkg::EIS_RD:
          if (fall)
          begin
            if (cnt_q == 4'h8)
            begin
              oe_d = 1'b0;
              st_d = eis_pkg::EIS_MACK;
            end
            else
            begin
              oe_d  = ~sh_q[7];
              sh_d  = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        eis_pkg::EIS_MACK:
          if (rise)
          begin
            // Master not-acknowledge ends the read burst
            st_d  = sda_q[1] ? eis_pkg::EIS_IDLE : eis_pkg::EIS_ACK;
            ret_d = eis_pkg::EIS_RD;
          end
        default: st_d = eis_pkg::EIS_IDLE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      scl_q   <= 3'h7;
      sda_q   <= 3'h7;
      st_q    <= eis_pkg::EIS_IDLE;
      ret_q   <= eis_pkg::EIS_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= 8'h00;
      oe_q    <= 1'b0;
      bus.wr  <= 1'b0;
    end
    else
    begin
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      st_q    <= st_d;
      ret_q   <= ret_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      oe_q    <= oe_d;
      bus.wr  <= wr_d;
    end
  end

  // Write strobe carries the pointer and byte of the previous cycle
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      bus.wdata <= 8'h00;
    else if (wr_d)
      bus.wdata <= sh_q;
  end

  assign bus.addr   = (st_q == eis_pkg::EIS_ACK && bus.wr) ? ptr_q - 8'h01 : ptr_q;
  assign sda_oe_out = oe_q;
endmodule : eis_i2c_slave
`default_nettype wire

/* eis_pkg.sv */
// Types shared by the snapshot bank and its serial slave
`default_nettype none
package eis_pkg;
  typedef enum logic [2:0] {
    EIS_IDLE, EIS_ADDR, EIS_PTR, EIS_WR, EIS_ACK, EIS_RD, EIS_MACK
  } eis_state_t;
endpackage : eis_pkg
`default_nettype wire

/* eis_reg_if.sv */
// Register access carrier between serial slave and register bank
`timescale 1ns/1ps
`default_nettype none
interface eis_reg_if;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr, output addr, output wdata, input rdata);
  modport bank  (input wr, input addr, input wdata, output rdata);
endinterface : eis_reg_if
`default_nettype wire

/* eis_snapshot_regs.sv */
// Event input snapshot register bank behind the two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "eis_defines.svh"
module eis_snapshot_regs (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic [3:0]  lower_event_inputs_in,
  input  wire logic [7:0]  upper_event_inputs_in,
  input  wire logic [15:0] unread_count_in,
  output logic [7:0]       upper_event_enable_out,
  output logic [15:0]      unread_count_capture_out
);
  eis_reg_if  rif ();
  logic [11:0] pin_s1_q, pin_s2_q;
  logic [11:0] lvl_q, lvl_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  en_q, en_d;
  logic        cmd_wr, input_level_capture, unread_count_capture;

  // Read decode; unused offsets return zero
  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] en,
                                          input logic [11:0] lvl, input logic [15:0] cnt);
    if (a == `EIS_OFS_EN_UPPER)
      read_mux = en;
    else if (a == `EIS_OFS_LVL_LOWER)
      read_mux = {4'h0, lvl[3:0]};
    else if (a == `EIS_OFS_LVL_UPPER)
      read_mux = lvl[11:4];
    else if (a == `EIS_OFS_CNT_LSB)
      read_mux = cnt[7:0];
    else if (a == `EIS_OFS_CNT_MSB)
      read_mux = cnt[15:8];
    else
      read_mux = `EIS_READ_NONE; // Command register is write-only
  endfunction : read_mux

  eis_i2c_slave u_slave (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .sda_oe_out (sda_oe_out),
    .bus        (rif.slave)
  );

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;

  // Event inputs are asynchronous pins, two flops before any use
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pin_s1_q <= `EIS_RST_LVL;
      pin_s2_q <= `EIS_RST_LVL;
    end
    else
    begin
      pin_s1_q <= {upper_event_inputs_in, lower_event_inputs_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Command strobes decoded from the write byte
  assign cmd_wr               = rif.wr && rif.addr == `EIS_OFS_INPUT_LEVEL_CAPTURE_CMD;
  assign input_level_capture  = cmd_wr && rif.wdata[`EIS_BIT_LVL_CAP];
  assign unread_count_capture = cmd_wr && rif.wdata[`EIS_BIT_CNT_CAP];

  // Next values; nothing else touches the captures
  always_comb
  begin
    lvl_d = lvl_q;
    cnt_d = cnt_q;
    en_d  = en_q;
    if (input_level_capture)
      lvl_d = pin_s2_q;
    if (unread_count_capture)
      cnt_d = unread_count_in;
    if (rif.wr && rif.addr == `EIS_OFS_EN_UPPER)
      en_d = rif.wdata;
  end

  // Register storage
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      lvl_q <= `EIS_RST_LVL;
      cnt_q <= `EIS_RST_CNT;
      en_q  <= `EIS_RST_EN_UPPER;
    end
    else
    begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      en_q  <= en_d;
    end
  end

  // Read data and outputs to the rest of the recorder
  assign rif.rdata                = read_mux(rif.addr, en_q, lvl_q, cnt_q);
  assign upper_event_enable_out   = en_q;
  assign unread_count_capture_out = cnt_q;

  // Checks
  sequence s_lvl_cmd;
    rif.wr && rif.addr == `EIS_OFS_INPUT_LEVEL_CAPTURE_CMD && rif.wdata[0];
  endsequence

  sequence s_cnt_cmd;
    rif.wr && rif.addr == `EIS_OFS_INPUT_LEVEL_CAPTURE_CMD && rif.wdata[1];
  endsequence

  property p_upper_read;
    @(posedge clock_in) disable iff (rst_in)
      rif.addr == `EIS_OFS_LVL_UPPER |-> rif.rdata == lvl_q[11:4];
  endproperty
  a_upper_read: assert property (p_upper_read)
    else $error("upper level read wrong");

  property p_lower_read;
    @(posedge clock_in) disable iff (rst_in)
      rif.addr == `EIS_OFS_LVL_LOWER |-> rif.rdata == {4'h0, lvl_q[3:0]};
  endproperty
  a_lower_read: assert property (p_lower_read)
    else $error("lower level read wrong");

  property p_cnt_input_level_capture;
    @(posedge clock_in) disable iff (rst_in)
      s_cnt_cmd |=> unread_count_capture_out == $past(unread_count_in);
  endproperty
  a_cnt_input_level_capture: assert property (p_cnt_input_level_capture)
    else $error("count snapshot missed");

  property p_lvl_input_level_capture;
    @(posedge clock_in) disable iff (rst_in)
      s_lvl_cmd |=> lvl_q == $past({upper_event_inputs_in, lower_event_inputs_in}, 3);
  endproperty
  a_lvl_input_level_capture: assert property (p_lvl_input_level_capture)
    else $error("level snapshot missed");

  sequence s_en_wr;
    rif.wr && rif.addr == `EIS_OFS_EN_UPPER;
  endsequence

  // Both halves checked on their own so a lost write cannot pass vacuously
  property p_enable_write;
    @(posedge clock_in) disable iff (rst_in)
      s_en_wr |=> (upper_event_enable_out == $past(rif.wdata))
        and (rif.addr == `EIS_OFS_EN_UPPER |-> rif.rdata == upper_event_enable_out);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable write lost");

  property p_lvl_hold;
    @(posedge clock_in) disable iff (rst_in)
      !input_level_capture |=> $stable(lvl_q);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold)
    else $error("levels changed without command");

  property p_cnt_hold;
    @(posedge clock_in) disable iff (rst_in)
      !unread_count_capture |=> $stable(unread_count_capture_out);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("count changed without command");

  property p_enable_hold;
    @(posedge clock_in) disable iff (rst_in)
      !(rif.wr && rif.addr == `EIS_OFS_EN_UPPER) |=> $stable(upper_event_enable_out);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable changed without write");

  // Read side of the remaining offsets
  property p_enable_read;
    @(posedge clock_in) disable iff (rst_in)
      rif.addr == `EIS_OFS_EN_UPPER |-> rif.rdata == upper_event_enable_out;
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("enable read wrong");

  property p_cmd_read;
    @(posedge clock_in) disable iff (rst_in)
      rif.addr == `EIS_OFS_INPUT_LEVEL_CAPTURE_CMD |-> rif.rdata == 8'h00;
  endproperty
  a_cmd_read: assert property (p_cmd_read)
    else $error("command register read not zero");

  property p_cnt_lsb_read;
    @(posedge clock_in) disable iff (rst_in)
      rif.addr == `EIS_OFS_CNT_LSB |-> rif.rdata == unread_count_capture_out[7:0];
  endproperty
  a_cnt_lsb_read: assert property (p_cnt_lsb_read)
    else $error("count low byte read wrong");

  property p_cnt_msb_read;
    @(posedge clock_in) disable iff (rst_in)
      rif.addr == `EIS_OFS_CNT_MSB |-> rif.rdata == unread_count_capture_out[15:8];
  endproperty
  a_cnt_msb_read: assert property (p_cnt_msb_read)
    else $error("count high byte read wrong");

  // One strobe per byte, so a command samples the pins only once
  property p_wr_single;
    @(posedge clock_in) disable iff (rst_in)
      rif.wr |=> !rif.wr;
  endproperty
  a_wr_single: assert property (p_wr_single)
    else $error("write strobe longer than one cycle");
endmodule : eis_snapshot_regs
`default_nettype wire

/* eis_snapshot_regs_bench.sv */
// Self-checking bench for the event input snapshot bank
`timescale 1ns/1ps
`default_nettype none
`include "eis_defines.svh"
module eis_snapshot_regs_bench;
  logic        clock_in   = 1'b0;
  logic        rst_in     = 1'b1;
  logic [3:0]  lower_in   = 4'h0;
  logic [7:0]  upper_in   = 8'h00;
  logic [15:0] count_in   = 16'h0000;
  logic        scl_line;
  logic        host_oe;
  logic        dut_oe;
  logic        dut_sda;
  logic        sda_line;
  logic [7:0]  enable_seen;
  logic [15:0] capture_seen;
  logic [8:0]  rx;
  logic [7:0]  got[$];
  int          fail_count   = 0;
  int          total_checks = 0;

  // Open drain data line with pull-up
  assign sda_line = ~host_oe & (dut_oe ? dut_sda : 1'b1);

  // 50 MHz clock
  initial forever #10 clock_in = ~clock_in;

  eis_snapshot_regs dut (
    .clock_in                 (clock_in),
    .rst_in                   (rst_in),
    .scl_in                   (scl_line),
    .sda_in                   (sda_line),
    .sda_out                  (dut_sda),
    .sda_oe_out               (dut_oe),
    .lower_event_inputs_in    (lower_in),
    .upper_event_inputs_in    (upper_in),
    .unread_count_in          (count_in),
    .upper_event_enable_out   (enable_seen),
    .unread_count_capture_out (capture_seen)
  );

  eis_host_model host (
    .clock_in   (clock_in),
    .sda_in     (sda_line),
    .scl_out    (scl_line),
    .sda_oe_out (host_oe)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One byte written, device must acknowledge
  task automatic send(input logic [7:0] b);
    host.xfer({b, 1'b1}, rx);
    check(16'(rx[0]), 16'h0000);
  endtask : send

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    host.start();
    send({`EIS_DEV_ADDR, 1'b0});
    send(ptr);
    foreach (d[i]) send(d[i]);
    host.stop();
  endtask : wr

  // Pointer set, repeated start, n bytes read, last one refused
  task automatic rd(input logic [7:0] ptr, input int n);
    got.delete();
    host.start();
    send({`EIS_DEV_ADDR, 1'b0});
    send(ptr);
    host.start();
    send({`EIS_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++)
    begin
      host.xfer({8'hFF, i == n - 1}, rx);
      got.push_back(rx[8:1]);
    end
    host.stop();
  endtask : rd

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clock_in);
    fail_count++;
    give_verdict();
  end

  // Main sequence; inputs change on the falling edge
  initial
  begin
    repeat (16) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    check(16'(enable_seen), 16'(`EIS_RST_EN_UPPER));
    check(capture_seen, `EIS_RST_CNT);
    lower_in = 4'hA;
    upper_in = 8'h5C;
    count_in = 16'h1234;
    // Enables, level snapshot only, then a write into a read-only place
    wr(8'h26, '{8'hC3, 8'h01, 8'hFF});
    check(16'(enable_seen), 16'h00C3);
    check(capture_seen, 16'h0000);
    lower_in = 4'h5;
    upper_in = 8'hA3;
    count_in = 16'hBEEF;
    wr(8'h27, '{8'h02});
    check(capture_seen, 16'hBEEF);
    lower_in = 4'hF;
    upper_in = 8'hFF;
    count_in = 16'h0F0F;
    rd(8'h26, 6);
    check(16'(got[0]), 16'h00C3);
    check(16'(got[1]), 16'h0000);
    check(16'(got[2]), 16'h000A);
    check(16'(got[3]), 16'h005C);
    check(16'(got[4]), 16'h00EF);
    check(16'(got[5]), 16'h00BE);
    check(capture_seen, 16'hBEEF);
    wr(8'h27, '{8'h03});
    check(capture_seen, 16'h0F0F);
    // Foreign device address must stay unanswered
    host.start();
    host.xfer({`EIS_DEV_ADDR ^ 7'h01, 1'b0, 1'b1}, rx);
    check(16'(rx[0]), 16'h0001);
    host.stop();
    give_verdict();
  end
endmodule : eis_snapshot_regs_bench
`default_nettype wire
